// ### src/adgu_core.sv
// address generation datapath: pointer file, modulo unit, pointer 3 inc/dec unit
// assumes requests are decoded by the program controller one instruction per clock
`timescale 1ns/1ps
`default_nettype none

module adgu_core
    import adgu_pkg::*;
#(
    parameter logic [15:0] ONCHIP_LAST = 16'h07ff
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // global data bus moves
    input wire adgu_mv_t i_mv,
    input wire logic i_next_uses_offset,
    output logic [15:0] o_gbus_rdata,
    output logic o_stretch,
    // address request
    input wire adgu_op_t i_op,
    output logic o_ptr_hazard,
    output logic o_dual_err,
    // address buses
    output logic [15:0] o_prim_addr,
    output logic o_prim_en,
    output logic [15:0] o_sec_addr,
    output logic o_sec_en,
    output logic o_sec_err,
    output logic [15:0] o_pgm_addr,
    output logic o_pgm_en
);

    if (ADDR_W != 16) begin : g_width_check
        $error("address width must be 16");
    end

    logic [15:0] ptr_ff [0:3];
    logic [15:0] stack_ff;
    logic [15:0] offset_ff;
    logic [15:0] modifier_ff;
    logic pend_vld_ff;
    logic [2:0] pend_sel_ff;
    logic [15:0] pend_data_ff;

    logic [2:0] op_ptr;
    logic [15:0] cur_ptr;
    logic [15:0] step_val;
    logic [15:0] linear;
    logic [15:0] mod_mask;
    logic [15:0] mod_base;
    logic signed [17:0] full_sum;
    logic signed [17:0] mod_top;
    logic signed [17:0] mod_size;
    logic mod_en;
    logic wrap;
    logic [15:0] mau_out;
    logic mau_wr;
    logic incdec_wr;
    logic [15:0] incdec_out;
    logic delayed_wr;

    function automatic logic [15:0] reg_of(input logic [2:0] sel, input logic [15:0] p0,
        input logic [15:0] p1, input logic [15:0] p2, input logic [15:0] p3,
        input logic [15:0] st, input logic [15:0] of, input logic [15:0] md);
        logic [15:0] r;
        r = READ_ZERO;
        unique case (sel)
            SEL_PTR0: r = p0;
            SEL_PTR1: r = p1;
            SEL_PTR2: r = p2;
            SEL_PTR3: r = p3;
            SEL_STACK: r = st;
            SEL_OFFSET: r = of;
            SEL_MODIFIER: r = md;
            default: r = READ_ZERO;
        endcase
        return r;
    endfunction : reg_of

    // pop always walks the stack downward
    assign op_ptr = i_op.pop ? SEL_STACK : i_op.ptr;

    always_comb begin
        cur_ptr = stack_ff;
        if (op_ptr < SEL_STACK) begin
            cur_ptr = ptr_ff[op_ptr[1:0]];
        end
    end

    // offset applies to every pointer and the stack
    always_comb begin
        step_val = READ_ZERO;
        if (i_op.pop) begin
            step_val = STEP_MINUS_ONE;
        end else begin
            unique case (i_op.step)
                STEP_NONE: step_val = READ_ZERO;
                STEP_INC: step_val = STEP_ONE;
                STEP_DEC: step_val = STEP_MINUS_ONE;
                STEP_OFFSET: step_val = offset_ff;
            endcase
        end
    end

    // 16-bit sum drops the carry, so linear updates wrap
    assign linear = cur_ptr + step_val;

    // modifier only for pointer 0, or pointer 1 on request
    assign mod_en = ((op_ptr == SEL_PTR0) || (op_ptr == SEL_PTR1 && i_op.use_mod1))
        && (modifier_ff != MODIFIER_LINEAR);

    always_comb begin
        mod_mask = modifier_ff;
        for (int i = 1; i < 16; i++) begin
            mod_mask = mod_mask | (mod_mask >> 1);
        end
    end

    // buffer base is the pointer aligned to the power of two covering the modulus
    assign mod_base = cur_ptr & ~mod_mask;
    assign mod_top = $signed({2'b00, mod_base}) + $signed({2'b00, modifier_ff});
    assign mod_size = $signed({2'b00, modifier_ff}) + 18'sd1;
    assign full_sum = $signed({2'b00, cur_ptr}) + $signed({{2{step_val[15]}}, step_val});

    // wraparound only when the linear sum leaves the buffer
    assign wrap = mod_en && (step_val[15] ? (full_sum < $signed({2'b00, mod_base}))
        : (full_sum > mod_top));

    always_comb begin
        mau_out = linear;
        if (wrap) begin
            if (step_val[15]) begin
                mau_out = 16'(full_sum + mod_size);
            end else begin
                mau_out = 16'(full_sum - mod_size);
            end
        end
    end

    assign mau_wr = i_op.valid && !i_op.index && (i_op.pop || i_op.step != STEP_NONE);
    assign o_dual_err = i_op.valid && i_op.dual && (op_ptr == SEL_PTR3);
    assign incdec_wr = i_op.valid && i_op.dual && !o_dual_err;
    assign incdec_out = ptr_ff[3] + (i_op.dual_dec ? STEP_MINUS_ONE : STEP_ONE);

    // move or bit-op writes to pointers, stack and modifier, and bit-op writes
    // to the offset, sit one cycle in a pending stage before they land
    assign delayed_wr = i_mv.wr && i_mv.sel <= SEL_MODIFIER
        && (i_mv.sel != SEL_OFFSET || i_mv.bitop);

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pend_vld_ff <= 1'b0;
            pend_sel_ff <= SEL_PTR0;
            pend_data_ff <= PTR_RESET;
        end else begin
            pend_vld_ff <= delayed_wr;
            pend_sel_ff <= i_mv.sel;
            pend_data_ff <= i_mv.data;
        end
    end

    // a pointer used while its new value is still pending gets the old value
    assign o_ptr_hazard = i_op.valid && pend_vld_ff && (pend_sel_ff == op_ptr
        || pend_sel_ff == SEL_MODIFIER || (i_op.dual && pend_sel_ff == SEL_PTR3)
        || (i_op.step == STEP_OFFSET && pend_sel_ff == SEL_OFFSET));

    // pointer file: pending move beats the modulo unit, which beats inc/dec
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < 4; i++) begin
                ptr_ff[i] <= PTR_RESET;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (pend_vld_ff && pend_sel_ff == 3'(i)) begin
                    ptr_ff[i] <= pend_data_ff;
                end else if (mau_wr && op_ptr == 3'(i)) begin
                    ptr_ff[i] <= mau_out;
                end else if (incdec_wr && i == 3) begin
                    ptr_ff[i] <= incdec_out;
                end
            end
        end
    end

    // stack resets to zero like the pointers; software must load it
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            stack_ff <= PTR_RESET;
        end else if (pend_vld_ff && pend_sel_ff == SEL_STACK) begin
            stack_ff <= pend_data_ff;
        end else if (mau_wr && op_ptr == SEL_STACK) begin
            stack_ff <= linear;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            modifier_ff <= MODIFIER_RESET;
        end else if (pend_vld_ff && pend_sel_ff == SEL_MODIFIER) begin
            modifier_ff <= pend_data_ff;
        end
    end

    // a plain move reaches the offset at once
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            offset_ff <= PTR_RESET;
        end else if (i_mv.wr && !i_mv.bitop && i_mv.sel == SEL_OFFSET) begin
            offset_ff <= i_mv.data;
        end else if (pend_vld_ff && pend_sel_ff == SEL_OFFSET) begin
            offset_ff <= pend_data_ff;
        end
    end

    // extra cycle only when the very next instruction needs the new offset
    assign o_stretch = i_mv.wr && !i_mv.bitop && i_mv.sel == SEL_OFFSET
        && i_next_uses_offset;

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_gbus_rdata <= READ_ZERO;
        end else if (i_mv.rd) begin
            o_gbus_rdata <= reg_of(i_mv.sel, ptr_ff[0], ptr_ff[1], ptr_ff[2], ptr_ff[3],
                stack_ff, offset_ff, modifier_ff);
        end
    end

    // address buses, registered; indexed modes issue the sum on the primary bus, others the pointer; the program bus always takes the pointer
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_prim_addr <= READ_ZERO;
            o_prim_en <= 1'b0;
            o_pgm_addr <= READ_ZERO;
            o_pgm_en <= 1'b0;
        end else begin
            o_prim_en <= i_op.valid && !i_op.prog && !i_op.ea_only;
            o_pgm_en <= i_op.valid && i_op.prog && !i_op.ea_only;
            if (i_op.valid) begin
                o_prim_addr <= i_op.index ? mau_out : cur_ptr;
                o_pgm_addr <= cur_ptr;
            end
        end
    end

    // second read only to on-chip memory; an off-chip address is blocked
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_sec_addr <= READ_ZERO;
            o_sec_en <= 1'b0;
            o_sec_err <= 1'b0;
        end else begin
            o_sec_en <= incdec_wr && ptr_ff[3] <= ONCHIP_LAST;
            o_sec_err <= incdec_wr && ptr_ff[3] > ONCHIP_LAST;
            if (incdec_wr) begin
                o_sec_addr <= ptr_ff[3];
            end
        end
    end

    a_modifier_reset: assert property (@(posedge i_sys_clk)
        i_sys_rst |=> modifier_ff == MODIFIER_RESET)
        else $error("modifier not all ones after reset");

    a_ptr_move_delay: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mv.wr && i_mv.sel <= SEL_PTR3)
        |-> ##2 ptr_ff[$past(i_mv.sel[1:0], 2)] == $past(i_mv.data, 2))
        else $error("moved pointer not landed two cycles later");

    a_offset_move_now: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        (i_mv.wr && !i_mv.bitop && i_mv.sel == SEL_OFFSET) |=> offset_ff == $past(i_mv.data))
        else $error("offset move not visible next cycle");

    a_offset_bitop_late: assert property (@(posedge i_sys_clk)
        disable iff (i_sys_rst)
        (i_mv.wr && i_mv.bitop && i_mv.sel == SEL_OFFSET && !$past(delayed_wr)
        && offset_ff != i_mv.data) |=> offset_ff != $past(i_mv.data))
        else $error("offset bit-op write visible too early");

    a_linear_wrap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (mau_wr && op_ptr <= SEL_PTR3 && !mod_en && i_op.step == STEP_INC
        && cur_ptr == 16'hffff && !pend_vld_ff) |=> ptr_ff[$past(op_ptr[1:0])] == 16'h0000)
        else $error("linear update did not wrap to zero");

    a_no_mod_high: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_op.valid && i_op.index && !i_op.pop && op_ptr >= SEL_PTR2)
        |=> o_prim_addr == $past(cur_ptr + step_val))
        else $error("modifier affected pointer 2, 3 or stack");

    a_mod_wrap: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (mau_wr && op_ptr == SEL_PTR0 && i_op.step == STEP_INC && modifier_ff == 16'h0003
        && ptr_ff[0] == 16'h0003 && !pend_vld_ff) |=> ptr_ff[0] == 16'h0000)
        else $error("modulo increment did not wrap");

    a_incdec_linear: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (incdec_wr && !i_op.dual_dec && !pend_vld_ff) |=> ptr_ff[3] == $past(ptr_ff[3]) + 16'h0001)
        else $error("pointer 3 not incremented in dual read");

    a_sec_onchip: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_sec_en |-> o_sec_addr <= ONCHIP_LAST && !o_sec_err)
        else $error("secondary address left on-chip memory");

    a_pop_dec: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_op.valid && i_op.pop && !i_op.index && !pend_vld_ff)
        |=> stack_ff == $past(stack_ff) - 16'h0001)
        else $error("stack not decremented after pop");

    a_dual_both: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (incdec_wr && !i_op.ea_only && !i_op.prog) |=> o_prim_en && (o_sec_en || o_sec_err))
        else $error("dual read did not issue two addresses");

    a_old_ptr_used: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mv.wr && i_mv.sel <= SEL_PTR3 ##1 i_op.valid && !i_op.pop && !i_op.index
        && i_op.ptr == $past(i_mv.sel)) |=> o_prim_addr == $past(ptr_ff[i_op.ptr[1:0]]))
        else $error("pending pointer move used too early");

    a_mod_wrap_down: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (mau_wr && op_ptr == SEL_PTR0 && i_op.step == STEP_DEC && modifier_ff == 16'h0003
        && ptr_ff[0] == 16'h0000 && !pend_vld_ff) |=> ptr_ff[0] == 16'h0003)
        else $error("modulo decrement did not wrap");

    a_pgm_addr_issue: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_op.valid && i_op.prog && !i_op.ea_only) |=> o_pgm_en && !o_prim_en
        && o_pgm_addr == $past(cur_ptr))
        else $error("program access not on program address bus");

    a_offset_stretch: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_mv.wr && !i_mv.bitop && i_mv.sel == SEL_OFFSET) |-> o_stretch == i_next_uses_offset)
        else $error("offset move stretch does not follow next use");

    a_pop_address: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_op.valid && i_op.pop && !i_op.index && !i_op.prog && !i_op.ea_only)
        |=> o_prim_en && o_prim_addr == $past(stack_ff))
        else $error("pop did not address the old stack top");

    a_mod_low_only: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_op.valid && op_ptr >= SEL_PTR2) |-> !wrap)
        else $error("modulo wrap on pointer 2, 3 or stack");

    c_dual_read: cover property (@(posedge i_sys_clk) o_prim_en && o_sec_en);
    c_mod_wrap: cover property (@(posedge i_sys_clk) mau_wr && wrap);
    c_stretch: cover property (@(posedge i_sys_clk) o_stretch);
    c_pop: cover property (@(posedge i_sys_clk) i_op.valid && i_op.pop);

endmodule : adgu_core

`default_nettype wire

// ### src/adgu_pkg.sv
// address generation datapath: shared constants, register select codes and carrier types
// assumes a single instruction clock where one instruction cycle is one clock cycle
package adgu_pkg;

    localparam int ADDR_W = 16;

    // register select codes on the global data bus
    localparam logic [2:0] SEL_PTR0 = 3'h0;
    localparam logic [2:0] SEL_PTR1 = 3'h1;
    localparam logic [2:0] SEL_PTR2 = 3'h2;
    localparam logic [2:0] SEL_PTR3 = 3'h3;
    localparam logic [2:0] SEL_STACK = 3'h4;
    localparam logic [2:0] SEL_OFFSET = 3'h5;
    localparam logic [2:0] SEL_MODIFIER = 3'h6;

    // reset values and other fixed constants
    localparam logic [15:0] MODIFIER_RESET = 16'hffff;
    localparam logic [15:0] MODIFIER_LINEAR = 16'hffff;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    localparam logic [15:0] STEP_MINUS_ONE = 16'hffff;

    typedef enum logic [1:0] {
        STEP_NONE,
        STEP_INC,
        STEP_DEC,
        STEP_OFFSET
    } adgu_step_t;

    // one address request from the program controller
    typedef struct packed {
        logic valid;
        logic [2:0] ptr;
        adgu_step_t step;
        logic index;
        logic use_mod1;
        logic prog;
        logic ea_only;
        logic pop;
        logic dual;
        logic dual_dec;
    } adgu_op_t;

    // one register move on the global data bus
    typedef struct packed {
        logic wr;
        logic rd;
        logic bitop;
        logic [2:0] sel;
        logic [15:0] data;
    } adgu_mv_t;

endpackage : adgu_pkg

// ### verif/adgu_mem_model.sv
// partner model: x data memory answering the primary and secondary address buses
// assumes registered address and enable outputs from the address unit
`timescale 1ns/1ps
`default_nettype none
module adgu_mem_model
    import adgu_pkg::*;
#(
    parameter logic [15:0] ONCHIP_LAST = 16'h07ff,
    parameter logic [15:0] PATTERN = 16'h5a5a
) (
    // address buses
    input wire logic [15:0] i_prim_addr,
    input wire logic i_prim_en,
    input wire logic [15:0] i_sec_addr,
    input wire logic i_sec_en,
    // data buses
    output logic [15:0] o_gbus_data,
    output logic [15:0] o_sec_data,
    output logic o_sec_offchip
);
    logic [15:0] last_p = 16'h0000;
    logic [15:0] last_s = 16'h0000;

    // both operands come back in the cycle the addresses stand; idle buses show
    // the inverse of the last word so a stale value never looks valid
    always @* begin
        if (i_prim_en) begin
            last_p = i_prim_addr ^ PATTERN;
            o_gbus_data = last_p;
        end else begin
            o_gbus_data = ~last_p;
        end
        if (i_sec_en) begin
            last_s = i_sec_addr ^ PATTERN;
            o_sec_data = last_s;
        end else begin
            o_sec_data = ~last_s;
        end
    end

    // secondary accesses can only reach on-chip memory
    assign o_sec_offchip = i_sec_en && (i_sec_addr > ONCHIP_LAST);
endmodule : adgu_mem_model
`default_nettype wire

// ### verif/address_generation_unit_test.sv
// testbench: hand-written scenarios for the address generation datapath
// assumes one instruction per 100 ns clock; inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module address_generation_unit_test;
    import adgu_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    adgu_mv_t i_mv = '0;
    adgu_op_t i_op = '0;
    logic i_next_uses_offset = 1'b0;
    logic [15:0] o_gbus_rdata, o_prim_addr, o_sec_addr, o_pgm_addr, mem_p, mem_s;
    logic o_stretch, o_ptr_hazard, o_dual_err, o_prim_en, o_sec_en, o_sec_err, o_pgm_en;
    logic offchip, hz, de, st;
    int failures = 0;
    int cmp_count = 0;

    always #50 i_sys_clk = ~i_sys_clk;

    adgu_core uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_mv(i_mv),
        .i_next_uses_offset(i_next_uses_offset), .o_gbus_rdata(o_gbus_rdata),
        .o_stretch(o_stretch), .i_op(i_op), .o_ptr_hazard(o_ptr_hazard),
        .o_dual_err(o_dual_err), .o_prim_addr(o_prim_addr), .o_prim_en(o_prim_en),
        .o_sec_addr(o_sec_addr), .o_sec_en(o_sec_en), .o_sec_err(o_sec_err),
        .o_pgm_addr(o_pgm_addr), .o_pgm_en(o_pgm_en));
    adgu_mem_model mem (.i_prim_addr(o_prim_addr), .i_prim_en(o_prim_en),
        .i_sec_addr(o_sec_addr), .i_sec_en(o_sec_en), .o_gbus_data(mem_p),
        .o_sec_data(mem_s), .o_sec_offchip(offchip));

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chkb(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask : chkb

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // one instruction cycle; combinational flags are caught before the edge takes it
    task automatic cyc(input adgu_op_t o, input adgu_mv_t m, input logic nu);
        i_op = o;
        i_mv = m;
        i_next_uses_offset = nu;
        #10;
        hz = o_ptr_hazard;
        de = o_dual_err;
        st = o_stretch;
        @(negedge i_sys_clk);
    endtask : cyc

    function automatic adgu_op_t mk(input logic [2:0] p, input adgu_step_t s);
        mk = '0;
        mk.valid = 1'b1;
        mk.ptr = p;
        mk.step = s;
    endfunction : mk

    function automatic adgu_mv_t mw(input logic [2:0] sel, input logic [15:0] d, input logic b);
        mw = '0;
        mw.wr = 1'b1;
        mw.bitop = b;
        mw.sel = sel;
        mw.data = d;
    endfunction : mw

    task automatic wr(input logic [2:0] sel, input logic [15:0] d);
        cyc('0, mw(sel, d, 1'b0), 1'b0);
    endtask : wr

    task automatic op(input adgu_op_t o);
        cyc(o, '0, 1'b0);
    endtask : op

    // delayed writes land two edges later, so reads wait for them
    task automatic idle2();
        cyc('0, '0, 1'b0);
        cyc('0, '0, 1'b0);
    endtask : idle2

    task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
        adgu_mv_t m;
        m = '0;
        m.rd = 1'b1;
        m.sel = sel;
        cyc('0, m, 1'b0);
        chk16(o_gbus_rdata, exp, "register read");
    endtask : rd

    task automatic t_reset();
        for (int s = 0; s < 4; s++) begin
            rd(3'(s), 16'h0000);
        end
        rd(SEL_OFFSET, 16'h0000);
        rd(SEL_MODIFIER, 16'hffff);
        rd(3'h7, 16'h0000);
        $display("test reset values done");
    endtask : t_reset

    task automatic t_regs();
        for (int s = 0; s < 7; s++) begin
            wr(3'(s), 16'ha5a0 | 16'(s));
        end
        wr(3'h7, 16'h1234);
        idle2();
        for (int s = 0; s < 7; s++) begin
            rd(3'(s), 16'ha5a0 | 16'(s));
        end
        rd(3'h7, 16'h0000);
        wr(SEL_MODIFIER, 16'hffff);
        idle2();
        $display("test register moves done");
    endtask : t_regs

    task automatic t_hazard();
        wr(SEL_PTR2, 16'h0400);
        op(mk(SEL_PTR2, STEP_NONE));
        chkb(hz, 1'b1, "pending pointer flagged");
        chk16(o_prim_addr, 16'ha5a2, "old pointer used");
        op(mk(SEL_PTR2, STEP_NONE));
        chkb(hz, 1'b0, "no hazard after two");
        chk16(o_prim_addr, 16'h0400, "new pointer used");
        chkb(o_prim_en, 1'b1, "primary enable");
        $display("test pointer hazard done");
    endtask : t_hazard

    task automatic t_offset();
        adgu_op_t ix;
        ix = mk(SEL_PTR2, STEP_OFFSET);
        ix.index = 1'b1;
        cyc('0, mw(SEL_OFFSET, 16'h0010, 1'b0), 1'b1);
        chkb(st, 1'b1, "stretch when next uses offset");
        op(ix);
        chk16(o_prim_addr, 16'h0410, "offset move seen next");
        cyc('0, mw(SEL_OFFSET, 16'h0008, 1'b0), 1'b0);
        chkb(st, 1'b0, "no stretch otherwise");
        op(ix);
        chk16(o_prim_addr, 16'h0408, "offset move seen next");
        cyc('0, mw(SEL_OFFSET, 16'h0002, 1'b1), 1'b0);
        op(ix);
        chk16(o_prim_addr, 16'h0408, "bit-op offset still old");
        op(ix);
        chk16(o_prim_addr, 16'h0402, "bit-op offset now new");
        rd(SEL_PTR2, 16'h0400);
        $display("test offset timing done");
    endtask : t_offset

    task automatic t_dual();
        adgu_op_t d;
        d = mk(SEL_PTR0, STEP_INC);
        d.dual = 1'b1;
        wr(SEL_PTR0, 16'h0100);
        wr(SEL_PTR3, 16'h0200);
        idle2();
        op(d);
        chk16(o_prim_addr, 16'h0100, "primary address");
        chk16(o_sec_addr, 16'h0200, "secondary address");
        chkb(o_prim_en & o_sec_en, 1'b1, "both enables");
        chkb(offchip, 1'b0, "secondary on chip");
        chk16(mem_p, 16'h5b5a, "primary operand");
        chk16(mem_s, 16'h585a, "secondary operand");
        rd(SEL_PTR0, 16'h0101);
        rd(SEL_PTR3, 16'h0201);
        d.dual_dec = 1'b1;
        op(d);
        rd(SEL_PTR3, 16'h0200);
        wr(SEL_PTR3, 16'h0800);
        idle2();
        op(d);
        chkb(o_sec_err, 1'b1, "off-chip secondary refused");
        chkb(o_sec_en, 1'b0, "no secondary enable");
        rd(SEL_PTR3, 16'h07ff);
        d.ptr = SEL_PTR3;
        op(d);
        chkb(de, 1'b1, "dual on pointer three");
        chkb(o_sec_en, 1'b0, "no secondary enable");
        $display("test dual read done");
    endtask : t_dual

    task automatic t_modulo();
        adgu_op_t m;
        m = mk(SEL_PTR1, STEP_INC);
        m.use_mod1 = 1'b1;
        wr(SEL_MODIFIER, 16'h0003);
        wr(SEL_PTR0, 16'h0003);
        wr(SEL_PTR1, 16'h0003);
        wr(SEL_PTR2, 16'h0003);
        idle2();
        op(mk(SEL_PTR0, STEP_INC));
        rd(SEL_PTR0, 16'h0000);
        op(mk(SEL_PTR0, STEP_DEC));
        rd(SEL_PTR0, 16'h0003);
        op(mk(SEL_PTR0, STEP_OFFSET));
        rd(SEL_PTR0, 16'h0001);
        op(m);
        rd(SEL_PTR1, 16'h0000);
        op(mk(SEL_PTR1, STEP_INC));
        rd(SEL_PTR1, 16'h0001);
        op(mk(SEL_PTR2, STEP_INC));
        rd(SEL_PTR2, 16'h0004);
        op(mk(SEL_PTR0, STEP_OFFSET));
        wr(SEL_MODIFIER, 16'hffff);
        op(mk(SEL_PTR0, STEP_INC));
        rd(SEL_PTR0, 16'h0000);
        wr(SEL_PTR0, 16'hffff);
        idle2();
        op(mk(SEL_PTR0, STEP_INC));
        rd(SEL_PTR0, 16'h0000);
        $display("test modulo arithmetic done");
    endtask : t_modulo

    task automatic t_stack();
        adgu_op_t p;
        p = '0;
        p.valid = 1'b1;
        p.pop = 1'b1;
        wr(SEL_STACK, 16'h0300);
        wr(SEL_PTR2, 16'hfff0);
        idle2();
        op(p);
        chkb(hz, 1'b0, "pop spaced from stack write");
        chk16(o_prim_addr, 16'h0300, "pop address");
        rd(SEL_STACK, 16'h02ff);
        p = mk(SEL_STACK, STEP_OFFSET);
        p.index = 1'b1;
        op(p);
        chk16(o_prim_addr, 16'h0301, "stack indexed by offset");
        p = mk(SEL_PTR2, STEP_INC);
        p.prog = 1'b1;
        op(p);
        chkb(o_pgm_en, 1'b1, "program enable");
        chk16(o_pgm_addr, 16'hfff0, "program address");
        rd(SEL_PTR2, 16'hfff1);
        p = mk(SEL_PTR2, STEP_INC);
        p.ea_only = 1'b1;
        op(p);
        chkb(o_prim_en | o_pgm_en, 1'b0, "no bus for address only");
        rd(SEL_PTR2, 16'hfff2);
        $display("test stack and program done");
    endtask : t_stack

    // a hang is cut short well inside the cycle budget
    initial begin
        #2000000;
        failures++;
        $display("Error at %0t: run did not finish", $time);
        summarize();
    end

    initial begin
        repeat (5) @(negedge i_sys_clk);
        i_sys_rst = 1'b0;
        t_reset();
        t_regs();
        t_hazard();
        t_offset();
        t_dual();
        t_modulo();
        t_stack();
        summarize();
    end
endmodule : address_generation_unit_test
`default_nettype wire
